// >>> core/fdlsm_defines.vh
/*
  constants for the fan drive limit and stall monitor: register indices,
  field positions, reset values and drive-fail period counts.
  assumes the includer maps index n to byte address 4*n on the bus.
*/
`ifndef FDLSM_DEFINES_VH
`define FDLSM_DEFINES_VH

// ==========================================================
// register indices (byte address is four times the index)
`define FDLSM_IDX_CTRL 6'h00
`define FDLSM_IDX_SPIN_CFG 6'h06
`define FDLSM_IDX_RAMP 6'h07
`define FDLSM_IDX_FLOOR 6'h08
`define FDLSM_IDX_THRESH 6'h09
`define FDLSM_IDX_BAND 6'h0A
`define FDLSM_IDX_TARGET 6'h0C
`define FDLSM_IDX_TACH 6'h0E
`define FDLSM_IDX_BASE 6'h10
`define FDLSM_IDX_STATUS 6'h11
`define FDLSM_IDX_MANUAL 6'h12
`define FDLSM_IDX_DRIVE 6'h13

// ==========================================================
// field positions
`define FDLSM_CTRL_EN_BIT 7
`define FDLSM_CTRL_DERIV_HI 4
`define FDLSM_CTRL_DERIV_LO 3
`define FDLSM_SPIN_SEL_HI 7
`define FDLSM_SPIN_SEL_LO 6
`define FDLSM_STAT_STALL_BIT 0
`define FDLSM_STAT_SPIN_BIT 1
`define FDLSM_STAT_DFAIL_BIT 5

// ==========================================================
// reset values
`define FDLSM_RST_CTRL 8'h00
`define FDLSM_RST_RAMP 8'h10
`define FDLSM_RST_FLOOR 8'h66
`define FDLSM_RST_THRESH 8'hF5
`define FDLSM_RST_BAND 13'h0000
`define FDLSM_RST_TARGET 13'h1FFF
`define FDLSM_RST_MANUAL 8'h00

// ==========================================================
// codes and counts
`define FDLSM_OFF_CODE 8'hFF
`define FDLSM_FULL_HI 8'hFF
`define FDLSM_DUTY_MAX 10'h3FF
`define FDLSM_FAIL_PER_1 7'h10
`define FDLSM_FAIL_PER_2 7'h20
`define FDLSM_FAIL_PER_3 7'h40

`endif

// >>> core/fdlsm_fail_mon.v
/*
  drive-fail period counter: counts update ticks while full drive
  still leaves the fan short of target, and pulses on overrun.
  assumes tick is a one-cycle pulse on the same clock.
*/
`include "fdlsm_defines.vh"

module fdlsm_fail_mon (
  input wire ref_clk_i,
  input wire reset_n_i,
  input wire tick_i,
  input wire active_i,
  input wire short_i,
  input wire [1:0] sel_i,
  output reg fail_o
);

  reg [6:0] cnt_ff;
  reg [6:0] nxt_cnt;
  reg nxt_fail;

  function [6:0] period;
    input [1:0] sel;
    begin
      if (sel == 2'b11) period = `FDLSM_FAIL_PER_3;
      else if (sel == 2'b10) period = `FDLSM_FAIL_PER_2;
      else period = `FDLSM_FAIL_PER_1;
    end
  endfunction

  // ==========================================================
  // period count
  always @* begin
    nxt_cnt = cnt_ff;
    nxt_fail = 1'b0;
    if (!active_i || !short_i || (sel_i == 2'b00)) begin
      nxt_cnt = 7'h00;
    end else if (tick_i) begin
      // fail after more than the period
      if (cnt_ff >= period(sel_i)) begin
        nxt_fail = 1'b1;
        nxt_cnt = 7'h00;
      end else begin
        nxt_cnt = cnt_ff + 7'h01;
      end
    end
  end

  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cnt_ff <= 7'h00;
      fail_o <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      fail_o <= nxt_fail;
    end
  end

endmodule // fdlsm_fail_mon

// >>> core/fdlsm_step_limit.v
/*
  next duty value from present duty and requested duty: step cap,
  saturation at full scale and at the minimum drive floor.
  assumes present and requested values are 10-bit duty codes.
*/
`include "fdlsm_defines.vh"

module fdlsm_step_limit (
  input wire [9:0] cur_i,
  input wire [9:0] req_i,
  input wire [7:0] step_i,
  input wire limit_en_i,
  input wire mode8_i,
  input wire [7:0] floor_i,
  output reg [9:0] nxt_o
);

  reg [10:0] step10;
  reg [10:0] up;
  reg [10:0] floor10;
  reg [9:0] res;

  // ==========================================================
  // capped adjustment
  always @* begin
    step10 = 11'h000;
    up = 11'h000;
    floor10 = {1'b0, floor_i, 2'b00};
    res = req_i;
    // 8-bit mode scales step to full range
    step10 = mode8_i ? {1'b0, step_i, 2'b00} : {3'b000, step_i};
    if (limit_en_i && (req_i > cur_i)) begin
      up = {1'b0, cur_i} + step10;
      if (up > {1'b0, `FDLSM_DUTY_MAX}) begin
        up = {1'b0, `FDLSM_DUTY_MAX};
      end
      if (up < {1'b0, req_i}) begin
        res = up[9:0];
      end
    end else if (limit_en_i && (req_i < cur_i)) begin
      if ({1'b0, cur_i} > step10) begin
        up = {1'b0, cur_i} - step10;
      end
      if (up > {1'b0, req_i}) begin
        res = up[9:0];
      end
    end
    if (mode8_i) begin
      res = {res[9:2], 2'b00};
    end
    if ({1'b0, res} < floor10) begin
      res = floor10[9:0];
    end
    nxt_o = res;
  end

endmodule // fdlsm_step_limit

// >>> core/fdlsm_top.v
/*
  fan drive limit and stall monitor with an AHB-Lite register slave.
  assumes pid drive, tach count, update tick and spin-up handshake come
  from logic on the same clock; the spin-up routine itself is outside.
*/
// The AHB-Lite register port was chosen for this implementation.
// Behaviour
// - derivative option 0 or 1 caps each drive change at the step value
// - derivative option 2 or 3 applies drive changes without any step cap
// - base frequency 1..3 adds the 8-bit step to the 10-bit duty
// - base frequency 0 runs 8-bit duty, one step may span full scale
// - closed loop update ticks never set drive below floor unless target high byte is FFh; held drive can be lower
// - closed loop restarts a stopped fan automatically
// - in closed loop, end of each spin attempt compares tach with threshold, retries if slow
// - closed loop treats tach above threshold as stall and starts spin-up
// - open loop starts spin-up only when manual drive leaves zero
// - target above threshold, other than FFh, is ignored and present drive is held
// - drive-fail check runs only while drive high byte is full scale
// - shortfall longer than selected period sets drive-fail flag and event
// - fail band holds tach counts in bits 15:3, bits 2:0 reserved
// - floor, threshold and band act only with closed loop enabled
// - period code 3/2/1 gives 64/32/16 updates, 0 disables
// - target high FFh turns drive off, leaving FFh starts spin-up
// - tach counts slow clock periods per turn, larger means slower
`include "fdlsm_defines.vh"

module fdlsm_top #(
  parameter ADDR_W = 8
) (
  input wire ref_clk_i,
  input wire reset_n_i,
  input wire hsel_i,
  input wire [ADDR_W-1:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output wire [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  input wire update_tick_i,
  input wire [9:0] pid_drive_i,
  input wire [15:0] tach_count_i,
  input wire spin_active_i,
  input wire spin_end_i,
  output wire [9:0] drive_o,
  output wire spin_start_o,
  output wire drive_fail_o
);

  // ==========================================================
  // state
  reg wr_pend_ff;
  reg rd_pend_ff;
  reg [ADDR_W-3:0] idx_ff;
  reg [31:0] hrdata_ff;
  reg hready_ff;
  reg hresp_ff;
  reg [7:0] ctrl_ff;
  reg [1:0] fail_sel_ff;
  reg [7:0] ramp_ff;
  reg [7:0] floor_ff;
  reg [7:0] thresh_ff;
  reg [12:0] band_ff;
  reg [12:0] target_ff;
  reg [1:0] base_ff;
  reg [7:0] manual_ff;
  reg stall_ff;
  reg spin_fail_ff;
  reg dfail_ff;
  reg [9:0] drive_ff;
  reg spin_start_ff;
  reg dfail_evt_ff;
  reg [31:0] nxt_hrdata;
  reg [9:0] nxt_drive;

  wire accept;
  wire fsc_en;
  wire limit_en;
  wire mode8;
  wire [7:0] tgt_hi;
  wire [7:0] tach_hi;
  wire tgt_off;
  wire tgt_ignored;
  wire fan_slow;
  wire [9:0] limited;
  wire [16:0] short_lim;
  wire shortfall;
  wire fail_active;
  wire fail_pulse;
  wire start_tgt;
  wire start_manual;
  wire stall_evt;
  wire retry_evt;
  wire status_wr;

  // ==========================================================
  // bus decode helper
  function wr_hit;
    input pend;
    input [ADDR_W-3:0] idx;
    input [5:0] reg_idx;
    begin
      wr_hit = pend && (idx == reg_idx[ADDR_W-3:0]);
    end
  endfunction

  // only word accesses expected; narrower sizes are treated as words
  assign accept = hsel_i && htrans_i[1] && hready_i;

  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      idx_ff <= {(ADDR_W-2){1'b0}};
      hready_ff <= 1'b1;
      hresp_ff <= 1'b0;
      hrdata_ff <= 32'h00000000;
    end else begin
      wr_pend_ff <= accept && hwrite_i;
      rd_pend_ff <= accept && !hwrite_i;
      if (accept) begin
        idx_ff <= haddr_i[ADDR_W-1:2];
      end
      // one wait state on reads so data comes from a flop
      hready_ff <= !(accept && !hwrite_i);
      hresp_ff <= 1'b0;
      if (rd_pend_ff) begin
        hrdata_ff <= nxt_hrdata;
      end
    end
  end

  // ==========================================================
  // read mux, unmapped reads return zero
  always @* begin
    nxt_hrdata = 32'h00000000;
    if (idx_ff == `FDLSM_IDX_CTRL) begin
      nxt_hrdata[7:0] = ctrl_ff;
    end else if (idx_ff == `FDLSM_IDX_SPIN_CFG) begin
      nxt_hrdata[`FDLSM_SPIN_SEL_HI:`FDLSM_SPIN_SEL_LO] = fail_sel_ff;
    end else if (idx_ff == `FDLSM_IDX_RAMP) begin
      nxt_hrdata[7:0] = ramp_ff;
    end else if (idx_ff == `FDLSM_IDX_FLOOR) begin
      nxt_hrdata[7:0] = floor_ff;
    end else if (idx_ff == `FDLSM_IDX_THRESH) begin
      nxt_hrdata[7:0] = thresh_ff;
    end else if (idx_ff == `FDLSM_IDX_BAND) begin
      nxt_hrdata[15:3] = band_ff;
    end else if (idx_ff == `FDLSM_IDX_TARGET) begin
      nxt_hrdata[15:3] = target_ff;
    end else if (idx_ff == `FDLSM_IDX_TACH) begin
      nxt_hrdata[15:3] = tach_count_i[15:3];
    end else if (idx_ff == `FDLSM_IDX_BASE) begin
      nxt_hrdata[1:0] = base_ff;
    end else if (idx_ff == `FDLSM_IDX_STATUS) begin
      nxt_hrdata[`FDLSM_STAT_STALL_BIT] = stall_ff;
      nxt_hrdata[`FDLSM_STAT_SPIN_BIT] = spin_fail_ff;
      nxt_hrdata[`FDLSM_STAT_DFAIL_BIT] = dfail_ff;
    end else if (idx_ff == `FDLSM_IDX_MANUAL) begin
      nxt_hrdata[7:0] = manual_ff;
    end else if (idx_ff == `FDLSM_IDX_DRIVE) begin
      nxt_hrdata[9:0] = drive_ff;
    end
  end

  // ==========================================================
  // configuration registers
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ctrl_ff <= `FDLSM_RST_CTRL;
      fail_sel_ff <= 2'b00;
      ramp_ff <= `FDLSM_RST_RAMP;
      floor_ff <= `FDLSM_RST_FLOOR;
      thresh_ff <= `FDLSM_RST_THRESH;
      band_ff <= `FDLSM_RST_BAND;
      target_ff <= `FDLSM_RST_TARGET;
      base_ff <= 2'b00;
      manual_ff <= `FDLSM_RST_MANUAL;
    end else begin
      if (wr_hit(wr_pend_ff, idx_ff, `FDLSM_IDX_CTRL)) begin
        ctrl_ff <= hwdata_i[7:0];
      end
      if (wr_hit(wr_pend_ff, idx_ff, `FDLSM_IDX_SPIN_CFG)) begin
        fail_sel_ff <= hwdata_i[`FDLSM_SPIN_SEL_HI:`FDLSM_SPIN_SEL_LO];
      end
      if (wr_hit(wr_pend_ff, idx_ff, `FDLSM_IDX_RAMP)) begin
        ramp_ff <= hwdata_i[7:0];
      end
      if (wr_hit(wr_pend_ff, idx_ff, `FDLSM_IDX_FLOOR)) begin
        floor_ff <= hwdata_i[7:0];
      end
      if (wr_hit(wr_pend_ff, idx_ff, `FDLSM_IDX_THRESH)) begin
        thresh_ff <= hwdata_i[7:0];
      end
      if (wr_hit(wr_pend_ff, idx_ff, `FDLSM_IDX_BAND)) begin
        band_ff <= hwdata_i[15:3];
      end
      if (wr_hit(wr_pend_ff, idx_ff, `FDLSM_IDX_TARGET)) begin
        target_ff <= hwdata_i[15:3];
      end
      if (wr_hit(wr_pend_ff, idx_ff, `FDLSM_IDX_BASE)) begin
        base_ff <= hwdata_i[1:0];
      end
      if (wr_hit(wr_pend_ff, idx_ff, `FDLSM_IDX_MANUAL)) begin
        manual_ff <= hwdata_i[7:0];
      end
    end
  end

  // ==========================================================
  // control terms
  assign fsc_en = ctrl_ff[`FDLSM_CTRL_EN_BIT];
  // cap for options 0 and 1
  // no cap for options 2 and 3
  assign limit_en = !ctrl_ff[`FDLSM_CTRL_DERIV_HI];
  assign mode8 = (base_ff == 2'b00);
  assign tgt_hi = target_ff[12:5];
  assign tach_hi = tach_count_i[15:8];
  assign tgt_off = (tgt_hi == `FDLSM_OFF_CODE);
  assign tgt_ignored = (tgt_hi > thresh_ff);
  assign fan_slow = (tach_hi > thresh_ff);

  // ==========================================================
  // spin-up triggers
  // leaving off code starts spin-up
  assign start_tgt = fsc_en && tgt_off &&
    wr_hit(wr_pend_ff, idx_ff, `FDLSM_IDX_TARGET) && (hwdata_i[15:8] != `FDLSM_OFF_CODE);
  // open loop spin-up on leaving zero
  assign start_manual = !fsc_en && (manual_ff == 8'h00) &&
    wr_hit(wr_pend_ff, idx_ff, `FDLSM_IDX_MANUAL) && (hwdata_i[7:0] != 8'h00);
  assign stall_evt = fsc_en && update_tick_i && !spin_active_i && !tgt_off && fan_slow;
  assign retry_evt = fsc_en && spin_end_i && !tgt_off && fan_slow;
  assign status_wr = wr_hit(wr_pend_ff, idx_ff, `FDLSM_IDX_STATUS);

  // ==========================================================
  // step limiter and floor
  fdlsm_step_limit u_step (
    .cur_i(drive_ff),
    .req_i(pid_drive_i),
    .step_i(ramp_ff),
    .limit_en_i(limit_en),
    .mode8_i(mode8),
    .floor_i(floor_ff),
    .nxt_o(limited)
  );

  always @* begin
    nxt_drive = drive_ff;
    if (!fsc_en) begin
      nxt_drive = {manual_ff, 2'b00};
    end else if (tgt_off) begin
      nxt_drive = 10'h000;
    end else if (spin_active_i) begin
      nxt_drive = drive_ff;
    end else if (update_tick_i && !tgt_ignored) begin
      nxt_drive = limited;
    end
  end

  // ==========================================================
  // drive-fail monitor
  // short of target plus band in counts
  assign short_lim = {1'b0, target_ff, 3'b000} + {1'b0, band_ff, 3'b000};
  // reserved low tach bits kept out of the compare
  assign shortfall = ({1'b0, tach_count_i[15:3], 3'b000} > short_lim);
  assign fail_active = fsc_en && !tgt_off && (drive_ff[9:2] == `FDLSM_FULL_HI);

  fdlsm_fail_mon u_fail (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .tick_i(update_tick_i),
    .active_i(fail_active),
    .short_i(shortfall),
    .sel_i(fail_sel_ff),
    .fail_o(fail_pulse)
  );

  // ==========================================================
  // drive, status and events
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      drive_ff <= 10'h000;
      spin_start_ff <= 1'b0;
      dfail_evt_ff <= 1'b0;
      stall_ff <= 1'b0;
      spin_fail_ff <= 1'b0;
      dfail_ff <= 1'b0;
    end else begin
      drive_ff <= nxt_drive;
      spin_start_ff <= start_tgt || start_manual || stall_evt || retry_evt;
      dfail_evt_ff <= fail_pulse;
      // set wins over a same-cycle write-one clear
      stall_ff <= stall_evt ||
        (stall_ff && !(status_wr && hwdata_i[`FDLSM_STAT_STALL_BIT]));
      spin_fail_ff <= retry_evt ||
        (spin_fail_ff && !(status_wr && hwdata_i[`FDLSM_STAT_SPIN_BIT]));
      dfail_ff <= fail_pulse ||
        (dfail_ff && !(status_wr && hwdata_i[`FDLSM_STAT_DFAIL_BIT]));
    end
  end

  // ==========================================================
  // outputs
  assign hrdata_o = hrdata_ff;
  assign hreadyout_o = hready_ff;
  assign hresp_o = hresp_ff;
  assign drive_o = drive_ff;
  assign spin_start_o = spin_start_ff;
  assign drive_fail_o = dfail_evt_ff;

endmodule // fdlsm_top

// >>> tb/fdlsm_assertions.sv
/*
  port checker for the fan drive limit and stall monitor, bound to fdlsm_top.
  assumes one clock domain and a synchronous active-low reset.
*/
module fdlsm_assertions (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic update_tick_i,
  input wire logic spin_end_i,
  input wire logic [9:0] drive_o,
  input wire logic spin_start_o,
  input wire logic drive_fail_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // helper logic
  logic taken;
  logic wr_ph_ff;
  assign taken = hsel_i & htrans_i[1] & hready_i;
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) wr_ph_ff <= 1'b0;
    else wr_ph_ff <= taken & hwrite_i;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ==========
  // bus
  rd_wait_a: assert property (taken && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read data phase not one wait cycle");
  wr_ready_a: assert property (taken && hwrite_i |=> hreadyout_o)
    else $error("write data phase stalled");
  resp_okay_a: assert property (hresp_o == 1'b0)
    else $error("error response seen");
  // ==========
  // control
  // writes may move drive: off code, manual level
  drive_cause_a: assert property ($changed(drive_o) |->
    $past(update_tick_i) || $past(wr_ph_ff) || $past(wr_ph_ff, 2))
    else $error("drive moved without tick or write");
  spin_cause_a: assert property (spin_start_o |->
    $past(update_tick_i) || $past(spin_end_i) || $past(wr_ph_ff) || $past(wr_ph_ff, 2))
    else $error("spin start without cause");
  fail_tick_a: assert property (drive_fail_o |-> $past(update_tick_i, 2))
    else $error("drive fail not two cycles after tick");
  fail_full_a: assert property (drive_fail_o |-> $past(drive_o, 2) >= 10'h3FC)
    else $error("drive fail below full drive");
  fail_pulse_a: assert property (drive_fail_o |=> !drive_fail_o)
    else $error("drive fail longer than one cycle");
  rd_c: cover property (taken && !hwrite_i);
  spin_c: cover property (spin_start_o);
  fail_c: cover property (drive_fail_o);
endmodule // fdlsm_assertions

bind fdlsm_top fdlsm_assertions chk_u (
  .ref_clk_i(ref_clk_i),
  .reset_n_i(reset_n_i),
  .hsel_i(hsel_i),
  .htrans_i(htrans_i),
  .hwrite_i(hwrite_i),
  .hready_i(hready_i),
  .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o),
  .update_tick_i(update_tick_i),
  .spin_end_i(spin_end_i),
  .drive_o(drive_o),
  .spin_start_o(spin_start_o),
  .drive_fail_o(drive_fail_o)
);

// >>> tb/fdlsm_fan_model.sv
/*
  fan model: turns drive into a tach count.
  assumes the bench sets the running speed and may command a stall.
*/
module fdlsm_fan_model (
  input wire logic ref_clk_i,
  input wire logic [9:0] drive_i,
  input wire logic stall_i,
  input wire logic [7:0] speed_hi_i,
  output logic [15:0] tach_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] junk_ff = 3'h0;
  initial tach_o = 16'hFFF8;
  // ==========
  // stopped fan, largest count
  // reserved low bits churn so they are never trusted
  always @(posedge ref_clk_i) begin
    junk_ff <= junk_ff + 3'h5;
    if (stall_i || drive_i == 10'h000) tach_o <= {13'h1FFF, junk_ff};
    else tach_o <= {speed_hi_i, 5'h00, junk_ff};
  end
endmodule // fdlsm_fan_model

// >>> tb/tb_fan_drive_limits_stall_monitor.sv
/*
  self-checking bench for fdlsm_top with a fan model on the tach side.
  assumes the bench stands in for the pid core and the spin-up routine.
*/
module tb_fan_drive_limits_stall_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [7:0] haddr_i = 8'h00;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic update_tick_i = 1'b0;
  logic [9:0] pid_drive_i = 10'h000;
  logic spin_end_i = 1'b0;
  logic fan_stall = 1'b0;
  logic spin_act = 1'b0;
  logic [7:0] fan_speed = 8'h30;
  wire logic [31:0] hrdata_o;
  wire logic hreadyout_o;
  wire logic [15:0] tach_count_i;
  wire logic [9:0] drive_o;
  wire logic spin_start_o;
  wire logic drive_fail_o;
  logic [31:0] q;
  logic [31:0] cfg;
  logic [7:0] stp;
  logic [9:0] exp_d = 10'h000;
  logic ss;
  logic df;
  int i;
  int s;
  int per;
  int failures = 0;
  int comparisons = 0;
  int seed = 32'hf8e35bd8;
  logic [7:0] raddr [5] = '{8'h1C, 8'h20, 8'h24, 8'h28, 8'hFC};
  logic [31:0] rdef [5] = '{32'h10, 32'h66, 32'hF5, 32'h0, 32'h0};

  always #5 ref_clk_i = ~ref_clk_i;

  fdlsm_top #(.ADDR_W(8)) dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(), .update_tick_i(update_tick_i),
    .pid_drive_i(pid_drive_i), .tach_count_i(tach_count_i), .spin_active_i(spin_act),
    .spin_end_i(spin_end_i), .drive_o(drive_o), .spin_start_o(spin_start_o),
    .drive_fail_o(drive_fail_o));
  fdlsm_fan_model fan_u (.ref_clk_i(ref_clk_i), .drive_i(drive_o), .stall_i(fan_stall),
    .speed_hi_i(fan_speed), .tach_o(tach_count_i));

  // ==========
  // checks and bus
  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_evt(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    hsel_i <= 1'b1;
    haddr_i <= a;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    n = 0;
    do begin @(posedge ref_clk_i); n++; end while (hreadyout_o !== 1'b1 && n < 50);
    if (hreadyout_o !== 1'b1) begin failures++; tally_and_finish; end
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= d;
    do begin @(posedge ref_clk_i); n++; end while (hreadyout_o !== 1'b1 && n < 100);
    q = hrdata_o;
    if (hreadyout_o !== 1'b1) begin failures++; tally_and_finish; end
  endtask
  task automatic tick;
    update_tick_i <= 1'b1;
    @(posedge ref_clk_i);
    update_tick_i <= 1'b0;
    @(posedge ref_clk_i);
    ss = spin_start_o;
    @(posedge ref_clk_i);
    df = drive_fail_o;
  endtask
  // capped, saturated next duty; 8-bit mode works in steps of four
  function automatic logic [9:0] nd(input logic [9:0] c, input logic [9:0] r,
    input logic [7:0] st8, input logic [7:0] f, input logic cap, input logic m8);
    logic [10:0] st;
    logic [10:0] n;
    st = m8 ? {1'b0, st8, 2'b00} : {3'h0, st8};
    if (m8) c[1:0] = 2'b00;
    if (m8) r[1:0] = 2'b00;
    n = {1'b0, r};
    if (cap && r > c && r - c > st) n = c + st;
    if (cap && c > r && c - r > st) n = (c > st) ? c - st : 11'h0;
    if (n > 11'h3FF) n = 11'h3FF;
    if (n < {1'b0, f, 2'b00}) n = {1'b0, f, 2'b00};
    return n[9:0];
  endfunction

  // ==========
  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    for (i = 0; i < 5; i++) begin
      xfer(1'b0, raddr[i], 32'h0);
      chk_val(q, rdef[i]);
    end
    xfer(1'b1, 8'h28, 32'hFFFF);
    xfer(1'b0, 8'h28, 32'h0);
    chk_val(q, 32'hFFF8);
    xfer(1'b1, 8'h28, 32'h0);
    xfer(1'b1, 8'h20, 32'h40);
    xfer(1'b1, 8'h00, 32'h80);
    xfer(1'b1, 8'h30, 32'h3000);
    @(posedge ref_clk_i);
    chk_evt(spin_start_o, 1'b1);
    xfer(1'b1, 8'h30, 32'hF800);
    pid_drive_i <= 10'h200;
    tick;
    chk_val({22'h0, drive_o}, {22'h0, exp_d});
    xfer(1'b1, 8'h30, 32'h3000);
    for (i = 0; i < 24; i++) begin
      cfg = $random(seed);
      stp = (i == 0) ? 8'hFF : cfg[15:8];
      xfer(1'b1, 8'h00, {24'h0, 1'b1, 2'b00, cfg[1:0], 3'b000});
      xfer(1'b1, 8'h40, {30'h0, cfg[3:2]});
      xfer(1'b1, 8'h1C, {24'h0, stp});
      pid_drive_i <= cfg[25:16];
      tick;
      exp_d = nd(exp_d, cfg[25:16], stp, 8'h40, !cfg[1], cfg[3:2] == 2'b00);
      chk_val({22'h0, drive_o}, {22'h0, exp_d});
    end
    xfer(1'b1, 8'h30, 32'hFF00);
    // write lands at this edge, drive follows one edge later
    repeat (2) @(posedge ref_clk_i);
    chk_val({22'h0, drive_o}, 32'h0);
    fan_stall <= 1'b1;
    xfer(1'b1, 8'h30, 32'h3000);
    // spin-up running: no stall restart, drive held
    spin_act <= 1'b1;
    tick;
    chk_evt(ss, 1'b0);
    chk_val({22'h0, drive_o}, 32'h0);
    spin_act <= 1'b0;
    tick;
    chk_evt(ss, 1'b1);
    spin_end_i <= 1'b1;
    @(posedge ref_clk_i);
    spin_end_i <= 1'b0;
    @(posedge ref_clk_i);
    chk_evt(spin_start_o, 1'b1);
    xfer(1'b0, 8'h44, 32'h0);
    chk_val(q & 32'h3, 32'h3);
    fan_stall <= 1'b0;
    // no step cap here, so one tick reaches full drive
    xfer(1'b1, 8'h00, 32'h90);
    xfer(1'b1, 8'h30, 32'h2000);
    fan_speed <= 8'h40;
    for (s = 0; s < 4; s++) begin
      xfer(1'b1, 8'h18, {24'h0, s[1:0], 6'h00});
      pid_drive_i <= 10'h000;
      tick;
      pid_drive_i <= 10'h3FF;
      tick;
      per = (s == 0) ? 70 : (8 << s);
      for (i = 0; i <= per; i++) begin
        tick;
        chk_evt(df, s != 0 && i == per);
      end
    end
    xfer(1'b0, 8'h44, 32'h0);
    chk_val(q & 32'h20, 32'h20);
    xfer(1'b1, 8'h44, 32'h20);
    xfer(1'b0, 8'h44, 32'h0);
    chk_val(q & 32'h20, 32'h0);
    xfer(1'b1, 8'h00, 32'h0);
    xfer(1'b1, 8'h48, 32'h05);
    @(posedge ref_clk_i);
    chk_evt(spin_start_o, 1'b1);
    @(posedge ref_clk_i);
    chk_val({22'h0, drive_o}, 32'h14);
    tally_and_finish;
  end
endmodule // tb_fan_drive_limits_stall_monitor
